/* File: src/pteis_top.sv */
// timestamp unit event status flags, enables and combined event output
`default_nettype none
// Behaviour
// - set flag 8 on second port ingress capture
// - set flag 7 on second port egress capture
// - set flag 6 on first port ingress capture
// - set flag 5 on first port egress capture
// - set flag 4 on host ingress capture
// - set flag 3 on host egress capture
// - set flag 2 on pin b capture
// - set flag 1 on pin a capture
// - pins edge detected, held over 40 ns
// - set flag 0 when clock reaches target
// - optional pin edge clears target flag
// - packet enables bits 24..19, reset zero
// - pin and target enables bits 18..16
// - writing one clears a flag
// - flags record regardless of enables
// - set and enabled flags form event bit
module pteis_top
   import pteis_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [11:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [31:0] host_wdata,
   output logic [31:0] host_rdata,
   output logic host_rdata_valid,
   input wire logic second_port_ingress_stamp,
   input wire logic second_port_egress_stamp,
   input wire logic first_port_ingress_stamp,
   input wire logic first_port_egress_stamp,
   input wire logic host_port_ingress_stamp,
   input wire logic host_port_egress_stamp,
   input wire logic capture_pin_a,
   input wire logic capture_pin_b,
   input wire logic pin_a_active_high,
   input wire logic pin_b_active_high,
   input wire logic pin_a_capture_on,
   input wire logic pin_b_capture_on,
   input wire logic target_clear_on_pin,
   input wire logic [63:0] clock_now,
   input wire logic [31:0] clock_target_upper_word,
   input wire logic [31:0] clock_target_lower_word,
   input wire logic system_timestamp_event_enable,
   output logic pin_a_edge,
   output logic pin_b_edge,
   output logic system_timestamp_event_bit,
   output logic system_interrupt_request
);
   typedef struct packed {
      logic [8:0] flags;
      logic [8:0] enables;
      logic [31:0] rdata;
      logic rvalid;
      logic event_bit;
      logic irq;
      logic edge_a;
      logic edge_b;
   } pteis_state_t;

   pteis_state_t state;
   pteis_state_t next_state;
   logic pulse_a;
   logic pulse_b;
   logic write_hit;
   logic read_hit;
   logic target_reached;
   logic any_active;
   logic [8:0] set_vec;
   logic [8:0] clear_vec;

   // exact match only; every other address reads as zero
   function automatic logic reg_hit(input logic [11:0] addr);
      reg_hit = (addr == STATUS_ENABLE_OFFSET);
   endfunction

   // the two capture pins share one filter design
   pteis_pin_filter filter_a (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin(capture_pin_a),
      .active_high(pin_a_active_high),
      .edge_pulse(pulse_a)
   );

   pteis_pin_filter filter_b (
      .sys_clk(sys_clk),
      .reset(reset),
      .pin(capture_pin_b),
      .active_high(pin_b_active_high),
      .edge_pulse(pulse_b)
   );

   // compare, decode, flag update and read path
   always_comb begin
      next_state = state;
      write_hit = host_wr && reg_hit(host_addr);
      read_hit = host_rd && reg_hit(host_addr);
      target_reached = (clock_now >= {clock_target_upper_word, clock_target_lower_word});

      // hardware events, gathered without looking at the enables
      set_vec = '0;
      set_vec[FLAG_SECOND_INGRESS] = second_port_ingress_stamp;
      set_vec[FLAG_SECOND_EGRESS] = second_port_egress_stamp;
      set_vec[FLAG_FIRST_INGRESS] = first_port_ingress_stamp;
      set_vec[FLAG_FIRST_EGRESS] = first_port_egress_stamp;
      set_vec[FLAG_HOST_INGRESS] = host_port_ingress_stamp;
      set_vec[FLAG_HOST_EGRESS] = host_port_egress_stamp;
      set_vec[FLAG_PIN_B] = pulse_b && pin_b_capture_on;
      set_vec[FLAG_PIN_A] = pulse_a && pin_a_capture_on;
      set_vec[FLAG_TARGET] = target_reached;

      // software write-one clears, plus the optional pin clear of the target flag
      clear_vec = '0;
      if (write_hit) begin
         clear_vec = host_wdata[FLAG_MSB:FLAG_LSB];
      end
      if (target_clear_on_pin && (pulse_a || pulse_b)) begin
         clear_vec[FLAG_TARGET] = 1'b1;
      end

      // set applied last so a same-cycle event survives its clear
      next_state.flags = (state.flags & ~clear_vec) | set_vec;

      if (write_hit) begin
         next_state.enables = host_wdata[ENABLE_MSB:ENABLE_LSB];
      end

      // combined event; system request also needs the upper enable
      any_active = |(state.flags & state.enables);
      next_state.event_bit = any_active;
      next_state.irq = any_active && system_timestamp_event_enable;

      // reserved fields are padded with zeros on read
      next_state.rvalid = host_rd;
      next_state.rdata = READ_IDLE;
      if (read_hit) begin
         next_state.rdata[FLAG_MSB:FLAG_LSB] = state.flags;
         next_state.rdata[ENABLE_MSB:ENABLE_LSB] = state.enables;
      end

      next_state.edge_a = pulse_a;
      next_state.edge_b = pulse_b;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state.flags <= FLAG_RESET;
         state.enables <= ENABLE_RESET;
         state.rdata <= READ_IDLE;
         state.rvalid <= 1'b0;
         state.event_bit <= 1'b0;
         state.irq <= 1'b0;
         state.edge_a <= 1'b0;
         state.edge_b <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // every output is a register bit
   assign host_rdata = state.rdata;
   assign host_rdata_valid = state.rvalid;
   assign system_timestamp_event_bit = state.event_bit;
   assign system_interrupt_request = state.irq;
   assign pin_a_edge = state.edge_a;
   assign pin_b_edge = state.edge_b;
endmodule
`default_nettype wire

/* File: src/pteis_pkg.sv */
// constants shared by the timestamp event status and enable logic
`default_nettype none
package pteis_pkg;
   // register placement on the host bus (byte address)
   localparam logic [11:0] STATUS_ENABLE_OFFSET = 12'h198;
   localparam int ADDR_WIDTH = 12;
   localparam int DATA_WIDTH = 32;

   // flag positions in the status half
   localparam int FLAG_COUNT = 9;
   localparam int FLAG_TARGET = 0;
   localparam int FLAG_PIN_A = 1;
   localparam int FLAG_PIN_B = 2;
   localparam int FLAG_HOST_EGRESS = 3;
   localparam int FLAG_HOST_INGRESS = 4;
   localparam int FLAG_FIRST_EGRESS = 5;
   localparam int FLAG_FIRST_INGRESS = 6;
   localparam int FLAG_SECOND_EGRESS = 7;
   localparam int FLAG_SECOND_INGRESS = 8;

   // field bounds of the register word
   localparam int FLAG_LSB = 0;
   localparam int FLAG_MSB = 8;
   localparam int ENABLE_LSB = 16;
   localparam int ENABLE_MSB = 24;

   // reset values
   localparam logic [8:0] FLAG_RESET = 9'h000;
   localparam logic [8:0] ENABLE_RESET = 9'h000;
   localparam logic [31:0] READ_IDLE = 32'h00000000;

   // least active time of a capture pin
   localparam int CLK_PERIOD_NS = 5;
   localparam int CAPTURE_MIN_NS = 40;
   localparam int CAPTURE_MIN_CYCLES = (CAPTURE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILTER_COUNT_WIDTH = 4;
   localparam logic [3:0] FILTER_COUNT_ZERO = 4'h0;
   localparam logic [3:0] FILTER_COUNT_ONE = 4'h1;
   localparam logic [3:0] FILTER_COUNT_TOP = 4'(CAPTURE_MIN_CYCLES);
endpackage
`default_nettype wire

/* File: src/pteis_pin_filter.sv */
// capture pin synchroniser, width filter and active edge pulse
`default_nettype none
module pteis_pin_filter
   import pteis_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic pin,
   input wire logic active_high,
   output logic edge_pulse
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic sync3;
      logic [3:0] count;
      logic pulse;
   } pteis_filter_t;

   pteis_filter_t state;
   pteis_filter_t next_state;
   logic agreed_active;

   // sync1 feeds only sync2; the agreement test looks at the later two stages
   always_comb begin
      next_state = state;
      next_state.sync1 = pin;
      next_state.sync2 = state.sync1;
      next_state.sync3 = state.sync2;
      agreed_active = (state.sync2 == state.sync3) && (state.sync3 == active_high);
      next_state.pulse = 1'b0;
      // one pulse per active period, only once it has lasted long enough
      if (agreed_active) begin
         if (state.count != FILTER_COUNT_TOP) begin
            next_state.count = state.count + FILTER_COUNT_ONE;
         end
         next_state.pulse = (state.count == FILTER_COUNT_TOP - FILTER_COUNT_ONE);
      end else begin
         next_state.count = FILTER_COUNT_ZERO; // short glitches never reach the top
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign edge_pulse = state.pulse;
endmodule
`default_nettype wire

/* File: verification/pteis_checker.sv */
// port assertions for the timestamp event status register
`default_nettype none
module pteis_checker
   import pteis_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [11:0] host_addr,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [31:0] host_wdata,
   input wire logic [31:0] host_rdata,
   input wire logic host_rdata_valid,
   input wire logic system_timestamp_event_enable,
   input wire logic pin_a_edge,
   input wire logic pin_b_edge,
   input wire logic system_timestamp_event_bit,
   input wire logic system_interrupt_request
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // read answer timing and idle value
   property p_rd_valid; host_rd |=> host_rdata_valid; endproperty
   a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
   property p_rd_idle; !host_rd |=> !host_rdata_valid && host_rdata == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_unmapped; host_rd && host_addr != STATUS_ENABLE_OFFSET |=> host_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_reserved; host_rdata_valid |-> host_rdata[31:25] == 7'h00 && host_rdata[15:9] == 7'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");
   // system request needs the system enable of the cycle before
   property p_irq; 1'b1 |-> system_interrupt_request ==
      (system_timestamp_event_bit && $past(system_timestamp_event_enable)); endproperty
   a_irq: assert property (p_irq) else $error("request not gated");
   // all enables off means no event two cycles later
   property p_en_zero; host_wr && host_addr == STATUS_ENABLE_OFFSET && host_wdata[24:16] == 9'h000
      |-> ##2 !system_timestamp_event_bit; endproperty
   a_en_zero: assert property (p_en_zero) else $error("event with enables off");
   property p_pulse_a; pin_a_edge |=> !pin_a_edge; endproperty
   a_pulse_a: assert property (p_pulse_a) else $error("pin a edge too long");
   property p_pulse_b; pin_b_edge |=> !pin_b_edge; endproperty
   a_pulse_b: assert property (p_pulse_b) else $error("pin b edge too long");
endmodule
bind pteis_top pteis_checker u_chk (.sys_clk(sys_clk), .reset(reset), .host_addr(host_addr),
   .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
   .host_rdata_valid(host_rdata_valid), .pin_a_edge(pin_a_edge), .pin_b_edge(pin_b_edge),
   .system_timestamp_event_enable(system_timestamp_event_enable),
   .system_timestamp_event_bit(system_timestamp_event_bit),
   .system_interrupt_request(system_interrupt_request));
`default_nettype wire

/* File: verification/test_pteis_top.sv */
// self-checking bench for the timestamp event status and enable register
`default_nettype none
module test_pteis_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] EN = 32'h01FF0000;
   logic sys_clk = 1'b0, reset = 1'b1, host_wr = 1'b0, host_rd = 1'b0, target_clear_on_pin = 1'b0;
   logic [11:0] host_addr = pteis_pkg::STATUS_ENABLE_OFFSET;
   logic [31:0] host_wdata = 32'h0, clock_target_upper_word = 32'hFFFFFFFF;
   logic [31:0] clock_target_lower_word = 32'h0, host_rdata;
   logic [63:0] clock_now = 64'h0;
   logic [5:0] stamps = 6'h00;
   logic capture_pin_a = 1'b0, capture_pin_b = 1'b1, pin_a_active_high = 1'b1;
   logic pin_b_active_high = 1'b0, pin_a_capture_on = 1'b1, pin_b_capture_on = 1'b1;
   logic system_timestamp_event_enable = 1'b1, host_rdata_valid, pin_a_edge, pin_b_edge;
   logic system_timestamp_event_bit, system_interrupt_request, second_port_ingress_stamp;
   logic second_port_egress_stamp, first_port_ingress_stamp, first_port_egress_stamp;
   logic host_port_ingress_stamp, host_port_egress_stamp;
   int err_total = 0, tests_run = 0, edges = 0;
   // stamp index k lands on flag k+3
   assign {second_port_ingress_stamp, second_port_egress_stamp, first_port_ingress_stamp,
      first_port_egress_stamp, host_port_ingress_stamp, host_port_egress_stamp} = stamps;
   pteis_top u_dut (.sys_clk, .reset, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
      .host_rdata_valid, .second_port_ingress_stamp, .second_port_egress_stamp,
      .first_port_ingress_stamp, .first_port_egress_stamp, .host_port_ingress_stamp,
      .host_port_egress_stamp, .capture_pin_a, .capture_pin_b, .pin_a_active_high,
      .pin_b_active_high, .pin_a_capture_on, .pin_b_capture_on, .target_clear_on_pin, .clock_now,
      .clock_target_upper_word, .clock_target_lower_word, .system_timestamp_event_enable,
      .pin_a_edge, .pin_b_edge, .system_timestamp_event_bit, .system_interrupt_request);
   always #2.5 sys_clk = ~sys_clk;
   // count edge pulses, one per accepted active period
   always @(posedge sys_clk) edges <= edges + int'(pin_a_edge) + int'(pin_b_edge);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] d);
      @(posedge sys_clk) begin
         host_wr <= 1'b1;
         host_wdata <= d;
      end
      @(posedge sys_clk) host_wr <= 1'b0;
   endtask
   // read data stands just after the taking edge and is checked 1 ns later
   task automatic rd(input logic [31:0] exp);
      @(posedge sys_clk) host_rd <= 1'b1;
      @(posedge sys_clk) host_rd <= 1'b0;
      #1 chk(host_rdata, exp);
   endtask
   task automatic stamp(input int k);
      @(posedge sys_clk) stamps <= 6'(1 << k);
      @(posedge sys_clk) stamps <= 6'h00;
   endtask
   // pin held active for n edges, then quiet long enough for the filter
   task automatic pin(input logic b, input int n);
      @(posedge sys_clk) begin
         capture_pin_a <= !b;
         capture_pin_b <= b ? 1'b0 : 1'b1;
      end
      repeat (n) @(posedge sys_clk);
      capture_pin_a <= 1'b0;
      capture_pin_b <= 1'b1;
      repeat (12) @(posedge sys_clk);
   endtask
   task automatic end_of_test;
      $display("errors %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #50000;
      err_total++;
      end_of_test;
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      rd(32'h0);
      wr(32'hFFFFFFFF);
      rd(EN);
      for (int k = 0; k < 6; k++) begin
         stamp(k);
         @(posedge sys_clk) #1 chk({31'h0, system_interrupt_request}, 32'h1);
         rd(EN | (32'h8 << k));
         wr(EN | (32'h8 << k));
         rd(EN);
      end
      // unmapped write and read change nothing
      @(posedge sys_clk) host_addr <= 12'h19C;
      wr(32'h0);
      rd(32'h0);
      @(posedge sys_clk) host_addr <= pteis_pkg::STATUS_ENABLE_OFFSET;
      rd(EN);
      wr(32'h0);
      stamp(5);
      wr(32'h0);
      rd(32'h100);
      chk({31'h0, system_timestamp_event_bit}, 32'h0);
      // set and clear on one edge: the set must win
      fork
         stamp(5);
         wr(32'h100);
      join
      rd(32'h100);
      wr(32'h100);
      clock_target_upper_word <= 32'h0;
      clock_target_lower_word <= 32'h64;
      clock_now <= 64'h63;
      rd(32'h0);
      clock_now <= 64'h64;
      rd(32'h1);
      clock_now <= 64'h63;
      wr(32'h1);
      rd(32'h0);
      clock_now <= 64'h64;
      @(posedge sys_clk) clock_now <= 64'h63;
      target_clear_on_pin <= 1'b1;
      pin(1'b0, 5);
      rd(32'h1);
      pin(1'b0, 12);
      rd(32'h2);
      pin(1'b1, 12);
      rd(32'h6);
      // system enable low holds the request back but not the event bit
      wr(32'h00060000);
      system_timestamp_event_enable <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 chk({system_timestamp_event_bit, system_interrupt_request}, 32'h2);
      @(posedge sys_clk) system_timestamp_event_enable <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1 chk({system_timestamp_event_bit, system_interrupt_request}, 32'h3);
      chk(32'(edges), 32'h2);
      end_of_test;
   end
endmodule
`default_nettype wire
